// File: dv/gio_pins_model.sv
// Board model: pins follow the port where driven, else the board level.
// Assumes the board holds every released pin at board_val.
`timescale 1ns/1ns
module gio_pins_model (
	// Port side
	input  wire logic [5:0] pin_out,
	input  wire logic [5:0] pin_oe,
	// Board side
	input  wire logic [5:0] board_val,
	output logic      [5:0] pin_in
);
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & board_val);
endmodule

// File: dv/gio_port_properties.sv
// Checker on the gio_port ports.
// Assumes one clock domain with srst as its reset.
`timescale 1ns/1ns
module gio_port_properties
	import gio_pkg::*;
#(
	parameter int unsigned PINS = 6
) (
	input wire logic            clk,
	input wire logic            srst,
	input wire logic            psel,
	input wire logic            penable,
	input wire logic            pwrite,
	input wire logic [11:0]     paddr,
	input wire logic [31:0]     pwdata,
	input wire logic [3:0]      pstrb,
	input wire logic [31:0]     prdata,
	input wire logic            pready,
	input wire logic            pslverr,
	input wire logic [PINS-1:0] pin_in,
	input wire logic [PINS-1:0] pin_oe,
	input wire logic [PINS-1:0] pin_in_buf_en,
	input wire logic [PINS-1:0] analog_enable,
	input wire logic [PINS-1:0] digital_in
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	wire acc = psel && penable;
	a_ready_access: assert property (pready == acc) else $error("pready wrong");
	a_pin3_undriven: assert property (!pin_oe[3]) else $error("pin 3 driven");
	a_buf_analog: assert property (pin_in_buf_en == ~analog_enable) else $error("buf en");
	a_analog_zero: assert property ((digital_in & analog_enable) == 0) else $error("dig in");
	a_reset_analog: assert property ($fell(srst) |-> analog_enable == 6'h17 && pin_oe == 0)
		else $error("reset state");
	a_dir_release: assert property (acc && pwrite && pstrb[0] && paddr == OFS_DIRECTION
		&& pwdata[5:0] == 6'h3F |=> pin_oe == 0) else $error("oe after dir");
	a_unmapped_err: assert property (acc && paddr == 12'h020 |-> pslverr && prdata == 0)
		else $error("unmapped");
	a_in_sync: assert property (!$past(srst) && !$past(srst, 2) |->
		digital_in == ($past(pin_in, 2) & ~analog_enable)) else $error("sync");
	a_rd_upper_zero: assert property (prdata[31:6] == 0) else $error("prdata hi");
	c_write: cover property (acc && pwrite);
	c_read: cover property (acc && !pwrite && paddr == OFS_PIN_VALUE);
	c_drive: cover property (pin_oe == 6'h37);
endmodule
bind gio_port gio_port_properties #(.PINS(PINS)) u_props (.clk(clk), .srst(srst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
	.pin_oe(pin_oe), .pin_in_buf_en(pin_in_buf_en), .analog_enable(analog_enable),
	.digital_in(digital_in));

// File: dv/six_bit_bidirectional_io_port_test.sv
// Testbench for gio_port over APB with a board model on the pins.
// Assumes zero-wait APB answers as the design provides.
`timescale 1ns/1ns
module six_bit_bidirectional_io_port_test;
	import gio_pkg::*;
	logic        clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [3:0]  pstrb = 0;
	logic [5:0]  pin_in, pin_out, pin_oe, buf_en, slew, ttl, ana, din;
	logic [5:0]  periph_out = 0, board = 6'h2D;
	int          n_mismatch = 0, n_compared = 0, cyc = 0;
	always #5 clk = ~clk;
	gio_port dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_in_buf_en(buf_en), .pin_slew_limit(slew), .pin_ttl_sel(ttl),
		.periph_out(periph_out), .analog_enable(ana), .digital_in(din));
	gio_pins_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .board_val(board),
		.pin_in(pin_in));
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
			n_mismatch++;
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge clk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 0; penable <= 0;
		#1;
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		xfer(0, a, 0, 4'h0);
		chk(rd, e);
	endtask
	task automatic t_reset();
		logic [5:0] ex [8] = '{6'h28, 0, 6'h3F, 6'h17, 0, 0, 0, 0};
		for (int i = 0; i < 8; i++) rdchk(12'(i * 4), ex[i]);
		chk(buf_en, 6'h28);
		$display("test reset done");
	endtask
	task automatic t_drive();
		xfer(1, OFS_ANALOG_SEL, 0, 4'h1);
		xfer(1, OFS_DIRECTION, 0, 4'h1);
		xfer(1, OFS_OUT_LATCH, 6'h15, 4'h1);
		chk(pin_out, 6'h15);
		chk(pin_oe, 6'h37);
		rdchk(OFS_DIRECTION, 6'h08);
		repeat (3) @(posedge clk);
		rdchk(OFS_PIN_VALUE, 6'h1D);
		xfer(1, OFS_PIN_VALUE, 6'h2A, 4'h1);
		rdchk(OFS_OUT_LATCH, 6'h2A);
		xfer(1, OFS_ANALOG_SEL, 6'h3F, 4'h1);
		rdchk(OFS_ANALOG_SEL, 6'h17);
		chk(ana, 6'h17);
		chk(pin_oe, 6'h37);
		repeat (3) @(posedge clk);
		rdchk(OFS_PIN_VALUE, 6'h28);
		chk(din, 6'h28);
		$display("test drive done");
	endtask
	task automatic t_rmw();
		xfer(1, OFS_DIRECTION, 6'h3F, 4'h1);
		chk(pin_oe, 0);
		xfer(1, OFS_ANALOG_SEL, 0, 4'h1);
		board = 6'h36;
		repeat (3) @(posedge clk);
		xfer(1, OFS_PIN_VALUE, 6'h3F, 4'h0);
		rdchk(OFS_OUT_LATCH, 6'h36);
		$display("test rmw done");
	endtask
	task automatic t_pad();
		xfer(1, OFS_DIRECTION, 0, 4'h1);
		xfer(1, OFS_OPEN_DRAIN, 6'h3F, 4'h1);
		xfer(1, OFS_OUT_LATCH, 6'h05, 4'h1);
		chk(pin_oe, 6'h32);
		xfer(1, OFS_OPEN_DRAIN, 0, 4'h1);
		chk(pin_oe, 6'h37);
		xfer(1, OFS_SLEW_LIMIT, 6'h2A, 4'h1);
		chk(slew, 6'h2A);
		xfer(1, OFS_IN_THRESHOLD, 6'h15, 4'h1);
		chk(ttl, 6'h15);
		$display("test pad done");
	endtask
	task automatic t_route();
		xfer(1, OFS_PERIPH_SEL, 6'h01, 4'h1);
		@(posedge clk);
		periph_out <= 6'h3E;
		#1;
		chk(pin_out, 6'h04);
		xfer(1, 12'h020, 6'h3F, 4'h1);
		chk(er, 1);
		rdchk(12'h020, 0);
		chk(er, 1);
		$display("test route done");
	endtask
	initial begin
		repeat (12) @(posedge clk);
		srst <= 0;
		// Pin synchroniser clears on reset and needs two edges to refill
		repeat (2) @(posedge clk);
		t_reset();
		t_drive();
		t_rmw();
		t_pad();
		t_route();
		final_report();
	end
endmodule

// File: logic/gio_apb_if.sv
// APB slave phase decode for the port registers.
// Assumes a compliant APB master; the slave never inserts wait states.
`timescale 1ns/1ns
module gio_apb_if (
	// APB control
	input  wire logic psel,
	input  wire logic penable,
	input  wire logic pwrite,
	// Decoded strobes
	output logic      setup_rd,
	output logic      access_wr,
	output logic      pready
);

	// Read data is captured in setup, so the access phase never waits
	assign setup_rd  = psel & ~penable & ~pwrite;
	assign access_wr = psel & penable & pwrite;
	assign pready    = psel & penable;

endmodule

// File: logic/gio_port.sv
// Six-bit bidirectional general purpose I/O port with APB registers.
// Assumes pin_in is sampled asynchronously; pad cells resolve oe/out.
// Function
// - Latch write equals port register write
// - Latch reads latch; port reads pins
// - Analog select disables digital input buffer
// - Six pins, per-pin control bits each
// - Direction one disables output driver
// - Direction zero drives latch onto pin
// - Pin three input-only, direction reads one
// - Port writes are read-modify-write of pins
// - Direction still controls drivers in analog
// - Analog pins read zero digitally
// - Open-drain sinks only; else push-pull
// - Slew bit limits pin slew rate
// - Threshold bit selects Schmitt or TTL
// - Analog select leaves digital output working
// - Analog select bits set after reset
// - Outputs from latch unless routing selects
// - Analog functions active only in analog
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module gio_port
	import gio_pkg::*;
#(
	parameter int unsigned PINS = PIN_COUNT
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              srst,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Pins
	input  wire logic [PINS-1:0]   pin_in,
	output logic      [PINS-1:0]   pin_out,
	output logic      [PINS-1:0]   pin_oe,
	// Pad controls
	output logic      [PINS-1:0]   pin_in_buf_en,
	output logic      [PINS-1:0]   pin_slew_limit,
	output logic      [PINS-1:0]   pin_ttl_sel,
	// Peripheral routing
	input  wire logic [PINS-1:0]   periph_out,
	// Analog functions
	output logic      [PINS-1:0]   analog_enable,
	// Digital input levels for peripherals
	output logic      [PINS-1:0]   digital_in
);

	// Register state
	logic [PINS-1:0] output_latch_r;
	logic [PINS-1:0] output_latch_nxt;
	logic [PINS-1:0] direction_r;
	logic [PINS-1:0] direction_nxt;
	logic [PINS-1:0] analog_sel_r;
	logic [PINS-1:0] analog_sel_nxt;
	logic [PINS-1:0] open_drain_r;
	logic [PINS-1:0] open_drain_nxt;
	logic [PINS-1:0] slew_limit_r;
	logic [PINS-1:0] slew_limit_nxt;
	logic [PINS-1:0] threshold_r;
	logic [PINS-1:0] threshold_nxt;
	logic [PINS-1:0] periph_sel_r;
	logic [PINS-1:0] periph_sel_nxt;

	// Bus answer state
	logic [31:0]     prdata_r;
	logic [31:0]     prdata_nxt;
	logic            pslverr_r;
	logic            pslverr_nxt;

	// Bus strobes
	logic            setup_rd;
	logic            access_wr;

	// Pin view
	logic [PINS-1:0] pin_sync;
	logic [PINS-1:0] pin_read;
	logic [PINS-1:0] drive_val;
	logic [PINS-1:0] wr_mask;
	logic [PINS-1:0] wr_data;

	// True for any offset that holds a register
	function automatic logic addr_mapped(input logic [11:0] a);
		logic hit;
		hit = 1'b0;
		case (a)
			OFS_PIN_VALUE,
			OFS_OUT_LATCH,
			OFS_DIRECTION,
			OFS_ANALOG_SEL,
			OFS_OPEN_DRAIN,
			OFS_SLEW_LIMIT,
			OFS_IN_THRESHOLD,
			OFS_PERIPH_SEL: begin
				hit = 1'b1;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		return hit;
	endfunction

	// Merge written bits over a base value
	function automatic logic [PINS-1:0] merge_bits(
		input logic [PINS-1:0] base,
		input logic [PINS-1:0] data,
		input logic [PINS-1:0] mask
	);
		return (base & ~mask) | (data & mask);
	endfunction

	// Widen a pin vector into a read word
	function automatic logic [31:0] to_word(input logic [PINS-1:0] v);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[PINS-1:0] = v;
		return w;
	endfunction

	gio_apb_if u_apb (
		.psel      (psel),
		.penable   (penable),
		.pwrite    (pwrite),
		.setup_rd  (setup_rd),
		.access_wr (access_wr),
		.pready    (pready)
	);

	gio_sync #(
		.WIDTH (PINS)
	) u_sync (
		.clk      (clk),
		.srst     (srst),
		.async_in (pin_in),
		.sync_out (pin_sync)
	);

	// Digital read path with the input buffer gated off in analog mode
	always_comb begin
		pin_read = pin_sync & ~analog_sel_r;
	end

	// Only byte lane 0 carries pin bits
	always_comb begin
		wr_mask = {PINS{pstrb[0]}};
		wr_data = pwdata[PINS-1:0];
	end

	// Register next values
	always_comb begin
		output_latch_nxt = output_latch_r;
		direction_nxt    = direction_r;
		analog_sel_nxt   = analog_sel_r;
		open_drain_nxt   = open_drain_r;
		slew_limit_nxt   = slew_limit_r;
		threshold_nxt    = threshold_r;
		periph_sel_nxt   = periph_sel_r;
		if (srst) begin
			output_latch_nxt = RST_OUT_LATCH;
			direction_nxt    = RST_DIRECTION;
			analog_sel_nxt   = RST_ANALOG_SEL;
			open_drain_nxt   = RST_OPEN_DRAIN;
			slew_limit_nxt   = RST_SLEW_LIMIT;
			threshold_nxt    = RST_IN_THRESHOLD;
			periph_sel_nxt   = RST_PERIPH_SEL;
		end else if (access_wr) begin
			case (paddr)
				OFS_PIN_VALUE,
				OFS_OUT_LATCH: begin
					// Unwritten bits take the pin levels as read
					output_latch_nxt = merge_bits(pin_read, wr_data, wr_mask);
				end
				OFS_DIRECTION: begin
					direction_nxt = merge_bits(direction_r, wr_data, wr_mask)
						| INPUT_ONLY_MASK;
				end
				OFS_ANALOG_SEL: begin
					analog_sel_nxt = merge_bits(analog_sel_r, wr_data, wr_mask)
						& ANALOG_MASK;
				end
				OFS_OPEN_DRAIN: begin
					open_drain_nxt = merge_bits(open_drain_r, wr_data, wr_mask);
				end
				OFS_SLEW_LIMIT: begin
					slew_limit_nxt = merge_bits(slew_limit_r, wr_data, wr_mask);
				end
				OFS_IN_THRESHOLD: begin
					threshold_nxt = merge_bits(threshold_r, wr_data, wr_mask);
				end
				OFS_PERIPH_SEL: begin
					periph_sel_nxt = merge_bits(periph_sel_r, wr_data, wr_mask);
				end
				default: begin
					output_latch_nxt = output_latch_r;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		output_latch_r <= output_latch_nxt;
		direction_r    <= direction_nxt;
		analog_sel_r   <= analog_sel_nxt;
		open_drain_r   <= open_drain_nxt;
		slew_limit_r   <= slew_limit_nxt;
		threshold_r    <= threshold_nxt;
		periph_sel_r   <= periph_sel_nxt;
	end

	// Read data and error captured in setup, shown in access
	always_comb begin
		prdata_nxt  = prdata_r;
		pslverr_nxt = pslverr_r;
		if (srst) begin
			prdata_nxt  = 32'h0000_0000;
			pslverr_nxt = 1'b0;
		end else if (psel & ~penable) begin
			pslverr_nxt = ~addr_mapped(paddr);
			prdata_nxt  = 32'h0000_0000;
			if (setup_rd) begin
				case (paddr)
					OFS_PIN_VALUE: begin
						prdata_nxt = to_word(pin_read);
					end
					OFS_OUT_LATCH: begin
						prdata_nxt = to_word(output_latch_r);
					end
					OFS_DIRECTION: begin
						prdata_nxt = to_word(direction_r | INPUT_ONLY_MASK);
					end
					OFS_ANALOG_SEL: begin
						prdata_nxt = to_word(analog_sel_r & ANALOG_MASK);
					end
					OFS_OPEN_DRAIN: begin
						prdata_nxt = to_word(open_drain_r);
					end
					OFS_SLEW_LIMIT: begin
						prdata_nxt = to_word(slew_limit_r);
					end
					OFS_IN_THRESHOLD: begin
						prdata_nxt = to_word(threshold_r);
					end
					OFS_PERIPH_SEL: begin
						prdata_nxt = to_word(periph_sel_r);
					end
					default: begin
						prdata_nxt = 32'h0000_0000;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		prdata_r  <= prdata_nxt;
		pslverr_r <= pslverr_nxt;
	end

	assign prdata  = prdata_r;
	assign pslverr = pslverr_r & psel & penable;

	// Output source per pin: latch unless routing selects the peripheral
	always_comb begin
		drive_val = (output_latch_r & ~periph_sel_r) | (periph_out & periph_sel_r);
	end

	// Driver enables; analog select plays no part here
	always_comb begin
		pin_out = drive_val;
		// Open-drain pins only enable the driver to pull low
		pin_oe  = ~direction_r & ~(open_drain_r & drive_val)
			& ~INPUT_ONLY_MASK;
	end

	// Pad control straps, each pin independent
	always_comb begin
		pin_in_buf_en  = ~analog_sel_r;
		pin_slew_limit = slew_limit_r;
		pin_ttl_sel    = threshold_r;
		analog_enable  = analog_sel_r;
		digital_in     = pin_read;
	end

endmodule

// File: logic/gio_sync.sv
// Two-flop synchroniser for the raw pin levels.
// Assumes inputs may change at any time relative to clk.
`timescale 1ns/1ns
module gio_sync #(
	parameter int unsigned WIDTH = 6
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             srst,
	// Data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] meta_nxt;
	logic [WIDTH-1:0] sync_r;
	logic [WIDTH-1:0] sync_nxt;

	always_comb begin
		meta_nxt = srst ? '0 : async_in;
		sync_nxt = srst ? '0 : meta_r;
	end

	always_ff @(posedge clk) begin
		meta_r <= meta_nxt;
		sync_r <= sync_nxt;
	end

	assign sync_out = sync_r;

endmodule

// File: pkg/gio_pkg.sv
// Constants for the six-bit general purpose I/O port.
// Assumes a 32-bit APB register bus with one register per aligned word.
package gio_pkg;

	// Port geometry
	localparam int unsigned PIN_COUNT     = 6;
	localparam int unsigned INPUT_ONLY_PIN = 3;
	localparam int unsigned APB_AW        = 12;
	localparam int unsigned APB_DW        = 32;

	// Register byte offsets
	localparam logic [11:0] OFS_PIN_VALUE    = 12'h000;
	localparam logic [11:0] OFS_OUT_LATCH    = 12'h004;
	localparam logic [11:0] OFS_DIRECTION    = 12'h008;
	localparam logic [11:0] OFS_ANALOG_SEL   = 12'h00C;
	localparam logic [11:0] OFS_OPEN_DRAIN   = 12'h010;
	localparam logic [11:0] OFS_SLEW_LIMIT   = 12'h014;
	localparam logic [11:0] OFS_IN_THRESHOLD = 12'h018;
	localparam logic [11:0] OFS_PERIPH_SEL   = 12'h01C;

	// Implemented bits per register
	localparam logic [5:0] ALL_PINS_MASK   = 6'h3F;
	localparam logic [5:0] INPUT_ONLY_MASK = 6'h08;
	localparam logic [5:0] ANALOG_MASK     = 6'h17;

	// Reset values
	localparam logic [5:0] RST_OUT_LATCH    = 6'h00;
	localparam logic [5:0] RST_DIRECTION    = 6'h3F;
	localparam logic [5:0] RST_ANALOG_SEL   = 6'h17;
	localparam logic [5:0] RST_OPEN_DRAIN   = 6'h00;
	localparam logic [5:0] RST_SLEW_LIMIT   = 6'h00;
	localparam logic [5:0] RST_IN_THRESHOLD = 6'h00;
	localparam logic [5:0] RST_PERIPH_SEL   = 6'h00;

	// Synchroniser depth on pin inputs
	localparam int unsigned SYNC_STAGES = 2;

endpackage
